// *** hw/ccs_pkg.sv ***
// package: register map, field positions and types of the status/shutdown block
package ccs_pkg;
    // register byte offsets on the avalon slave
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] CON3_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] SRC_OFS = 4'hC;
    // control 3 register fields
    localparam int DT_LSB = 0;
    localparam int BDF_LSB = 16;
    // control register fields
    localparam int TRIGGERED_OPERATION_ENABLE_BIT = 0;
    localparam int RSEN_BIT = 1;
    localparam int GSM_LSB = 2;
    // status register field positions
    localparam int PRL_BIT = 20;
    localparam int TMRH_BIT = 19;
    localparam int TMRL_BIT = 18;
    localparam int RB_BIT = 17;
    localparam int RA_BIT = 16;
    localparam int ARM_BIT = 10;
    localparam int TRIG_BIT = 7;
    localparam int TRIGGER_SET_REQUEST_BIT = 6;
    localparam int TRIGGER_CLEAR_REQUEST_BIT = 5;
    localparam int AUTO_SHUTDOWN_EVENT_BIT = 4;
    localparam int SINGLE_EDGE_COMPARE_EVENT_BIT = 3;
    localparam int CAPTURE_DISABLE_BIT = 2;
    localparam int CAPTURE_FIFO_OVERFLOW_BIT = 1;
    localparam int CAPTURE_BUFFER_NOT_EMPTY_BIT = 0;
    // reset values and field encodings
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] GSM_LEVEL = 2'h0;
    localparam logic [1:0] GSM_RISE = 2'h1;
    localparam logic [1:0] GSM_FALL = 2'h2;
    localparam logic [1:0] PSS_ACTIVE = 2'h3;
    localparam logic [1:0] PSS_INACTIVE = 2'h2;
    localparam logic [5:0] DT_OFF = 6'h00;
    // one pin pair: drive level and output enable
    typedef struct packed {
        logic lvl;
        logic oe;
    } ccs_pin_s;
    // hardware event strobes from the module datapaths
    typedef struct packed {
        logic [4:0] wip;
        logic hw_trig;
        logic sc_event;
        logic cap_ovf;
        logic buf_ne;
        logic period_start;
    } ccs_evt_s;
endpackage : ccs_pkg

// *** hw/ccs_deadtime.sv ***
// one complementary channel pair with programmable dead time
`timescale 1ns/10ps
`default_nettype none
module ccs_deadtime (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic pwm_in,
    input wire logic [5:0] dt_in,
    output logic hi_out,
    output logic lo_out
);
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic prev_ff;
    logic hi_ff;
    logic lo_ff;
    wire edge_seen = pwm_in != prev_ff;
    wire dt_on = dt_in != ccs_pkg::DT_OFF;
    wire settle = cnt_ff == 6'h00;
    // a new edge restarts the gap so both sides are never high together
    // the edge cycle itself is the first dead period, so load one less
    assign nxt_cnt = edge_seen ? dt_in - 6'h01 :
        (settle ? 6'h00 : cnt_ff - 6'h01);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= 6'h00;
            prev_ff <= 1'b0;
            hi_ff <= 1'b0;
            lo_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            prev_ff <= pwm_in;
            hi_ff <= dt_on ? (pwm_in && !edge_seen && settle) : pwm_in;
            lo_ff <= dt_on ? (!pwm_in && !edge_seen && settle) : !pwm_in;
        end
    end
    assign hi_out = hi_ff;
    assign lo_out = lo_ff;
endmodule : ccs_deadtime
`default_nettype wire

// *** hw/ccs_top.sv ***
// status register, shutdown drive and dead-time output stage
// Summary of operation
// - in shutdown, the b pin is driven active, inactive or tristated per field
// - dead-time count n inserts n delay periods between complementary outputs
// - dead-time count zero disables the dead-time logic
// - shutdown state and dead-time fields exist only in multi-output variant
// - bit 20 reads one while period register update is in progress
// - bits 19 and 18 show timer high and low update in progress
// - bits 17 and 16 show compare b and a update in progress
// - writing one to bit 10 arms one-shot gating in modes 01/10
// - bit 7 shows timer triggered and running; clear request drops it
// - with triggered operation enabled, writing one to bit 6 triggers
// - with triggered operation enabled, writing one to bit 5 cancels
// - bit 4 reads one while shutdown holds outputs in shutdown state
// - bit 3 sets on single-edge compare event and is clearable
// - while capture disable is set, capture input events are blocked
// - bit 1 sets on capture fifo overflow and is clearable
// - bit 0 reads one whenever capture buffer holds data
// - unimplemented status bits always read zero
// - with restart enabled, shutdown flag clears at next period after input ends
// - gating 01 rising edge enables, 10 falling disables, 00 level-sensitive
`timescale 1ns/10ps
`default_nettype none
module ccs_top #(
    parameter bit MULTI_OUT = 1'b1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire ccs_pkg::ccs_evt_s evt_in,
    input wire logic pwm_in,
    input wire logic shutdown_pin_in,
    input wire logic gate_pin_in,
    input wire logic capture_pin_in,
    output logic capture_event_out,
    output logic timer_run_out,
    output ccs_pkg::ccs_pin_s pin_a_out,
    output ccs_pkg::ccs_pin_s pin_b_out
);
    // =====================================================
    // pin synchronisers
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic gate_d_ff;
    logic cap_d_ff;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_ff <= 3'h0;
            s2_ff <= 3'h0;
            gate_d_ff <= 1'b0;
            cap_d_ff <= 1'b0;
        end else begin
            s1_ff <= {shutdown_pin_in, gate_pin_in, capture_pin_in};
            s2_ff <= s1_ff;
            gate_d_ff <= s2_ff[1];
            cap_d_ff <= s2_ff[0];
        end
    end
    wire sd_lvl = s2_ff[2];
    wire gate_rise = s2_ff[1] && !gate_d_ff;
    wire gate_fall = !s2_ff[1] && gate_d_ff;
    wire cap_rise = s2_ff[0] && !cap_d_ff;

    // =====================================================
    // bus decode; every access completes one cycle after it is seen
    logic ack_ff;
    wire req = (avs_read_in || avs_write_in) && !ack_ff;
    // a write lands at the edge where waitrequest is seen low by the master
    wire wr = avs_write_in && ack_ff;
    wire wr_ctrl = wr && avs_address_in == ccs_pkg::CTRL_OFS;
    wire wr_con3 = wr && avs_address_in == ccs_pkg::CON3_OFS;
    wire wr_stat = wr && avs_address_in == ccs_pkg::STAT_OFS;
    wire [31:0] wd = avs_writedata_in;
    wire be0 = avs_byteenable_in[0];
    wire be1 = avs_byteenable_in[1];
    wire be2 = avs_byteenable_in[2];

    // =====================================================
    // control registers
    logic triggered_operation_enable_ff;
    logic rsen_ff;
    logic [1:0] gsm_ff;
    logic [1:0] pss_ff;
    logic [5:0] dt_ff;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            triggered_operation_enable_ff <= 1'b0;
            rsen_ff <= 1'b0;
            gsm_ff <= ccs_pkg::GSM_LEVEL;
            pss_ff <= 2'h0;
            dt_ff <= ccs_pkg::DT_OFF;
        end else begin
            if (wr_ctrl && be0) begin
                triggered_operation_enable_ff <= wd[ccs_pkg::TRIGGERED_OPERATION_ENABLE_BIT];
                rsen_ff <= wd[ccs_pkg::RSEN_BIT];
                gsm_ff <= wd[ccs_pkg::GSM_LSB +: 2];
            end
            // single-output builds keep these fields at zero
            if (wr_con3 && be2 && MULTI_OUT)
                pss_ff <= wd[ccs_pkg::BDF_LSB +: 2];
            if (wr_con3 && be0 && MULTI_OUT)
                dt_ff <= wd[ccs_pkg::DT_LSB +: 6];
        end
    end

    // =====================================================
    // status flags
    logic trig_ff;
    logic auto_shutdown_event_ff;
    logic single_edge_compare_event_ff;
    logic capture_disable_ff;
    logic capture_fifo_overflow_ff;
    logic armed_ff;
    wire set_req = wr_stat && be0 && wd[ccs_pkg::TRIGGER_SET_REQUEST_BIT] && triggered_operation_enable_ff;
    wire clr_req = wr_stat && be0 && wd[ccs_pkg::TRIGGER_CLEAR_REQUEST_BIT] && triggered_operation_enable_ff;
    wire arm_req = wr_stat && be1 && wd[ccs_pkg::ARM_BIT]
        && (gsm_ff == ccs_pkg::GSM_RISE || gsm_ff == ccs_pkg::GSM_FALL);
    // writing zero clears; set always wins over clear
    wire sw_clr_as = wr_stat && be0 && !wd[ccs_pkg::AUTO_SHUTDOWN_EVENT_BIT];
    wire sw_clr_sc = wr_stat && be0 && !wd[ccs_pkg::SINGLE_EDGE_COMPARE_EVENT_BIT];
    wire sw_clr_ov = wr_stat && be0 && !wd[ccs_pkg::CAPTURE_FIFO_OVERFLOW_BIT];
    wire hw_clr_as = rsen_ff && !sd_lvl && evt_in.period_start;
    wire gsm_level = gsm_ff == ccs_pkg::GSM_LEVEL;
    wire one_rise = armed_ff && gsm_ff == ccs_pkg::GSM_RISE && gate_rise;
    wire one_fall = armed_ff && gsm_ff == ccs_pkg::GSM_FALL && gate_fall;
    logic nxt_capture_disable;
    assign nxt_capture_disable = gsm_level ? !s2_ff[1] :
        (one_rise ? 1'b0 : (one_fall ? 1'b1 : capture_disable_ff));
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            trig_ff <= 1'b0;
            auto_shutdown_event_ff <= 1'b0;
            single_edge_compare_event_ff <= 1'b0;
            capture_disable_ff <= 1'b0;
            capture_fifo_overflow_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            // a clear request cancels even a same-cycle hardware trigger
            trig_ff <= clr_req ? 1'b0 :
                ((set_req || evt_in.hw_trig) ? 1'b1 : trig_ff);
            auto_shutdown_event_ff <= sd_lvl ? 1'b1 :
                ((sw_clr_as || hw_clr_as) ? 1'b0 : auto_shutdown_event_ff);
            single_edge_compare_event_ff <= evt_in.sc_event ? 1'b1 :
                (sw_clr_sc ? 1'b0 : single_edge_compare_event_ff);
            capture_fifo_overflow_ff <= evt_in.cap_ovf ? 1'b1 :
                (sw_clr_ov ? 1'b0 : capture_fifo_overflow_ff);
            capture_disable_ff <= nxt_capture_disable;
            armed_ff <= arm_req ? 1'b1 :
                ((one_rise || one_fall) ? 1'b0 : armed_ff);
        end
    end

    // =====================================================
    // read mux; unimplemented and write-only bits read zero
    logic [31:0] stat_word;
    always_comb begin
        stat_word = ccs_pkg::RST_WORD;
        stat_word[ccs_pkg::PRL_BIT] = evt_in.wip[4];
        stat_word[ccs_pkg::TMRH_BIT] = evt_in.wip[3];
        stat_word[ccs_pkg::TMRL_BIT] = evt_in.wip[2];
        stat_word[ccs_pkg::RB_BIT] = evt_in.wip[1];
        stat_word[ccs_pkg::RA_BIT] = evt_in.wip[0];
        stat_word[ccs_pkg::TRIG_BIT] = trig_ff;
        stat_word[ccs_pkg::AUTO_SHUTDOWN_EVENT_BIT] = auto_shutdown_event_ff;
        stat_word[ccs_pkg::SINGLE_EDGE_COMPARE_EVENT_BIT] = single_edge_compare_event_ff;
        stat_word[ccs_pkg::CAPTURE_DISABLE_BIT] = capture_disable_ff;
        stat_word[ccs_pkg::CAPTURE_FIFO_OVERFLOW_BIT] = capture_fifo_overflow_ff;
        stat_word[ccs_pkg::CAPTURE_BUFFER_NOT_EMPTY_BIT] = evt_in.buf_ne;
    end
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address_in)
            ccs_pkg::CTRL_OFS: rd_mux = {28'h0000000, gsm_ff, rsen_ff, triggered_operation_enable_ff};
            ccs_pkg::CON3_OFS: rd_mux = {14'h0000, pss_ff, 10'h000, dt_ff};
            ccs_pkg::STAT_OFS: rd_mux = stat_word;
            default: rd_mux = ccs_pkg::RST_WORD;
        endcase
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_ff <= 1'b0;
            avs_readdata_out <= ccs_pkg::RST_WORD;
        end else begin
            ack_ff <= req;
            if (req && avs_read_in)
                avs_readdata_out <= rd_mux;
        end
    end
    // waitrequest is low only in the cycle after the request was seen
    logic wait_ff;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            wait_ff <= 1'b1;
        else
            wait_ff <= !req;
    end
    assign avs_waitrequest_out = wait_ff;

    // =====================================================
    // output stage
    logic dt_hi;
    logic dt_lo;
    ccs_deadtime u_dt (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .pwm_in(pwm_in),
        .dt_in(dt_ff),
        .hi_out(dt_hi),
        .lo_out(dt_lo)
    );
    logic cap_ff;
    logic run_ff;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_a_out <= '0;
            pin_b_out <= '0;
            cap_ff <= 1'b0;
            run_ff <= 1'b0;
        end else begin
            pin_a_out <= '{lvl: dt_hi && !auto_shutdown_event_ff, oe: 1'b1};
            if (auto_shutdown_event_ff)
                pin_b_out <= '{lvl: pss_ff == ccs_pkg::PSS_ACTIVE,
                    oe: pss_ff[1]};
            else
                pin_b_out <= '{lvl: dt_lo, oe: 1'b1};
            cap_ff <= cap_rise && !capture_disable_ff;
            run_ff <= trig_ff;
        end
    end
    assign capture_event_out = cap_ff;
    assign timer_run_out = run_ff;

    // =====================================================
    // checks
    chk_shutdown_tri: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        auto_shutdown_event_ff && !pss_ff[1] |=> !pin_b_out.oe)
        else $error("b pin driven while shutdown tristate");
    chk_shutdown_act: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        auto_shutdown_event_ff && pss_ff == ccs_pkg::PSS_ACTIVE |=> pin_b_out.lvl && pin_b_out.oe)
        else $error("b pin not active in shutdown");
    chk_trig_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        clr_req |=> !trig_ff ##1 !timer_run_out)
        else $error("trigger not cancelled");
    chk_trig_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        set_req && !clr_req |=> trig_ff)
        else $error("trigger not set");
    chk_auto_shutdown_event_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        sd_lvl |=> auto_shutdown_event_ff)
        else $error("shutdown flag missing");
    chk_single_edge_compare_event_sticky: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        evt_in.sc_event |=> single_edge_compare_event_ff)
        else $error("compare flag lost");
    chk_capture_block: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        capture_disable_ff && $stable(capture_disable_ff) |=> !capture_event_out)
        else $error("capture while disabled");
    chk_ovf_sticky: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        evt_in.cap_ovf |=> capture_fifo_overflow_ff)
        else $error("overflow flag lost");
    chk_restart_clr: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        hw_clr_as |=> !auto_shutdown_event_ff)
        else $error("shutdown flag not auto cleared");
    chk_dt_gap: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !(dt_hi && dt_lo))
        else $error("complementary overlap");
endmodule : ccs_top
`default_nettype wire

// *** dv/ccs_pins_model.sv ***
// partner model: power stage leg and the capture-side input pins
`timescale 1ns/10ps
`default_nettype none
module ccs_pins_model (
    input wire logic clk_in,
    input wire logic [2:0] req_in,
    input wire ccs_pkg::ccs_pin_s pin_b_in,
    output logic shutdown_pin_out,
    output logic gate_pin_out,
    output logic capture_pin_out,
    output logic wire_b_out
);
    // ==========================================================
    // pin drive and bridge leg
    logic last_b;
    initial begin
        {shutdown_pin_out, gate_pin_out, capture_pin_out} = 3'h2;
        last_b = 1'b0;
    end
    // pins move just after an edge, like any outside source
    always @(posedge clk_in) begin
        {shutdown_pin_out, gate_pin_out, capture_pin_out} <= req_in;
    end
    always @(posedge clk_in) begin
        if (pin_b_in.oe) last_b <= pin_b_in.lvl;
    end
    // a floating leg must not look like the last driven level
    assign wire_b_out = pin_b_in.oe ? pin_b_in.lvl : ~last_b;
endmodule : ccs_pins_model
`default_nettype wire

// *** dv/ccs_top_test.sv ***
// testbench: register accesses, status flags, gating, dead time, shutdown
`timescale 1ns/10ps
`default_nettype none
module ccs_top_test;
    // ==========================================================
    // signals, instances and tasks
    localparam logic [3:0] CT = ccs_pkg::CTRL_OFS;
    localparam logic [3:0] C3 = ccs_pkg::CON3_OFS;
    localparam logic [3:0] ST = ccs_pkg::STAT_OFS;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic [31:0] q;
    logic wreq;
    ccs_pkg::ccs_evt_s evt = 10'h000;
    logic pwm = 1'b0;
    logic [2:0] req = 3'h2;
    logic sd, gate, cap, cap_ev, run, wire_b;
    ccs_pkg::ccs_pin_s pa, pb;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int gap;
    ccs_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .evt_in(evt), .pwm_in(pwm), .shutdown_pin_in(sd),
        .gate_pin_in(gate), .capture_pin_in(cap),
        .capture_event_out(cap_ev), .timer_run_out(run),
        .pin_a_out(pa), .pin_b_out(pb));
    ccs_pins_model pins (.clk_in(clk_in), .req_in(req), .pin_b_in(pb),
        .shutdown_pin_out(sd), .gate_pin_out(gate),
        .capture_pin_out(cap), .wire_b_out(wire_b));
    initial forever #2 clk_in = ~clk_in;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_n
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        do @(posedge clk_in); while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_in);
    endtask : acc
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, 4'hF);
        chk(q, exp);
    endtask : rdc
    task automatic cap_try(input logic [31:0] exp);
        gap = 0;
        req[0] <= 1'b1;
        repeat (10) begin
            @(posedge clk_in);
            req[0] <= 1'b0;
            if (cap_ev === 1'b1) gap++;
        end
        chk(gap, exp);
    endtask : cap_try
    task automatic dt_gap(input logic [5:0] n);
        acc(1'b1, C3, {26'h0, n}, 4'h1);
        pwm <= 1'b0;
        wait_n(70);
        pwm <= 1'b1;
        gap = 0;
        repeat (80) begin
            @(posedge clk_in);
            if (pa.lvl === 1'b0 && pb.lvl === 1'b0) gap++;
        end
        chk(gap, n);
    endtask : dt_gap
    initial begin
        wait_n(20);
        arst_n_in <= 1'b1;
        wait_n(6);
        rdc(ST, 32'h0);
        rdc(4'hC, 32'h0);
        evt.wip <= 5'h1F;
        evt.buf_ne <= 1'b1;
        wait_n(1);
        rdc(ST, 32'h001F0001);
        evt <= 10'h140;
        wait_n(1);
        rdc(ST, 32'h000A0000);
        evt <= 10'h000;
        acc(1'b1, ST, 32'h40, 4'h1);
        rdc(ST, 32'h0);
        acc(1'b1, CT, 32'h1, 4'h1);
        acc(1'b1, ST, 32'h40, 4'h1);
        rdc(ST, 32'h80);
        chk(run, 1'b1);
        acc(1'b1, ST, 32'h20, 4'h1);
        rdc(ST, 32'h0);
        evt.hw_trig <= 1'b1;
        wait_n(1);
        evt.hw_trig <= 1'b0;
        rdc(ST, 32'h80);
        acc(1'b1, ST, 32'h20, 4'h1);
        evt.sc_event <= 1'b1;
        evt.cap_ovf <= 1'b1;
        wait_n(1);
        evt <= 10'h000;
        rdc(ST, 32'h0A);
        acc(1'b1, ST, 32'h0A, 4'h1);
        rdc(ST, 32'h0A);
        acc(1'b1, ST, 32'h08, 4'h1);
        rdc(ST, 32'h08);
        acc(1'b1, ST, 32'h00, 4'h1);
        rdc(ST, 32'h0);
        cap_try(1);
        req[1] <= 1'b0;
        wait_n(6);
        rdc(ST, 32'h04);
        cap_try(0);
        req[1] <= 1'b1;
        wait_n(6);
        acc(1'b1, CT, 32'h9, 4'h1);
        acc(1'b1, ST, 32'h400, 4'h2);
        req[1] <= 1'b0;
        wait_n(6);
        rdc(ST, 32'h04);
        acc(1'b1, CT, 32'h5, 4'h1);
        acc(1'b1, ST, 32'h400, 4'h2);
        req[1] <= 1'b1;
        wait_n(6);
        rdc(ST, 32'h0);
        dt_gap(6'h00);
        dt_gap(6'h01);
        dt_gap(6'h3F);
        req[2] <= 1'b1;
        wait_n(6);
        rdc(ST, 32'h10);
        for (int p = 0; p < 4; p++) begin
            acc(1'b1, C3, 32'(p) << 16, 4'h4);
            wait_n(2);
            chk({pb.oe, pb.oe & wire_b}, p == 3 ? 2'h3 : {p == 2, 1'b0});
        end
        acc(1'b1, CT, 32'h7, 4'h1);
        req[2] <= 1'b0;
        wait_n(6);
        rdc(ST, 32'h10);
        evt.period_start <= 1'b1;
        wait_n(1);
        evt <= 10'h000;
        wait_n(2);
        rdc(ST, 32'h0);
        report_and_stop();
    end
endmodule : ccs_top_test
`default_nettype wire
